// *** core/event_irq_cfg.svh ***
`ifndef EVENT_IRQ_CFG_SVH
`define EVENT_IRQ_CFG_SVH
// register byte offsets
`define ENABLE_CLEAR_OFS 12'h010
`define ENABLE_SET_OFS   12'h014
`define FLAG_OFS         12'h018
`define PATH_ASYNC_OFS   12'h01c
// field positions
`define OVR_LSB          0
`define EVD_LSB          8
`define NUM_CHANNELS     6
// reset values
`define ENABLE_RESET     6'h00
`define FLAG_RESET       6'h00
`define PATH_RESET       6'h00
`endif

// *** core/event_irq_pkg.sv ***
package event_irq_pkg;
  typedef logic [5:0]  chan_vec_t;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {HTRANS_IDLE, HTRANS_BUSY, HTRANS_NONSEQ,
                            HTRANS_SEQ} htrans_t;
endpackage : event_irq_pkg

// *** core/event_channel_irq_logic.sv ***
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "event_irq_cfg.svh"
// Behaviour
// - writing one to an event enable bit via the set register sets it
// - writing one to an overrun enable bit via the set register sets it
// - set and clear registers read back the same shared enable bits
// - writing one via the clear register clears that enable; zero is ignored
// - event flag set one cycle after a channel event; requests irq if enabled
// - event flag never set on a channel with an asynchronous path
// - writing one to an event flag clears it; zero leaves it
// - overrun flag set next cycle after overrun; requests irq if enabled
// - overrun flag never set on a channel with an asynchronous path
// - writing one to an overrun flag clears it; zero leaves it
// - unused bits read zero; software writes zeros there
module event_channel_irq_logic
  import event_irq_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  channel_event_seen,
  input  wire logic [5:0]  channel_overrun,
  output logic             irq
);

  // ****************************************************************
  // address phase capture
  // ****************************************************************
  logic        wr_pend_reg;
  logic [11:0] addr_reg;
  wire         access_valid;
  wire         rd_now;

  // only NONSEQ/SEQ count; IDLE and BUSY are ignored
  assign access_valid = hsel & hready & htrans[1];
  assign rd_now       = access_valid & ~hwrite;

  // address held for the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 12'h000;
    end else begin
      wr_pend_reg <= access_valid & hwrite;
      addr_reg    <= haddr;
    end
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  wire       wr_set;
  wire       wr_clr;
  wire       wr_flag;
  wire       wr_path;
  chan_vec_t wd_evd;
  chan_vec_t wd_ovr;

  assign wr_set  = wr_pend_reg & (addr_reg == `ENABLE_SET_OFS);
  assign wr_clr  = wr_pend_reg & (addr_reg == `ENABLE_CLEAR_OFS);
  assign wr_flag = wr_pend_reg & (addr_reg == `FLAG_OFS);
  assign wr_path = wr_pend_reg & (addr_reg == `PATH_ASYNC_OFS);
  // bits 31:14 and 7:6 of write data are simply dropped
  assign wd_evd  = hwdata[`EVD_LSB +: `NUM_CHANNELS];
  assign wd_ovr  = hwdata[`OVR_LSB +: `NUM_CHANNELS];

  // ****************************************************************
  // enables, flags and path configuration
  // ****************************************************************
  chan_vec_t en_evd_reg;
  chan_vec_t en_ovr_reg;
  chan_vec_t flag_evd_reg;
  chan_vec_t flag_ovr_reg;
  chan_vec_t path_async_reg;
  chan_vec_t set_evd;
  chan_vec_t set_ovr;
  chan_vec_t en_evd_next;
  chan_vec_t en_ovr_next;
  chan_vec_t flag_evd_next;
  chan_vec_t flag_ovr_next;
  chan_vec_t path_async_next;

  // path config rewritten only by its own address, held otherwise
  assign path_async_next = wr_path ? wd_ovr : path_async_reg;

  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1) begin : g_chan
      // async paths bypass the clocked logic, so no flag
      assign set_evd[ch] = channel_event_seen[ch] & ~path_async_reg[ch];
      assign set_ovr[ch] = channel_overrun[ch] & ~path_async_reg[ch];
      // one-written set, one-written clear; set wins if both
      assign en_evd_next[ch] = (wr_set & wd_evd[ch]) |
                               (en_evd_reg[ch] & ~(wr_clr & wd_evd[ch]));
      assign en_ovr_next[ch] = (wr_set & wd_ovr[ch]) |
                               (en_ovr_reg[ch] & ~(wr_clr & wd_ovr[ch]));
      // hardware set beats one-to-clear
      assign flag_evd_next[ch] = set_evd[ch] |
                                 (flag_evd_reg[ch] & ~(wr_flag & wd_evd[ch]));
      assign flag_ovr_next[ch] = set_ovr[ch] |
                                 (flag_ovr_reg[ch] & ~(wr_flag & wd_ovr[ch]));
    end
  endgenerate

  // state registers; one shared enable store behind both addresses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_evd_reg     <= `ENABLE_RESET;
      en_ovr_reg     <= `ENABLE_RESET;
      flag_evd_reg   <= `FLAG_RESET;
      flag_ovr_reg   <= `FLAG_RESET;
      path_async_reg <= `PATH_RESET;
    end else begin
      en_evd_reg     <= en_evd_next;
      en_ovr_reg     <= en_ovr_next;
      flag_evd_reg   <= flag_evd_next;
      flag_ovr_reg   <= flag_ovr_next;
      path_async_reg <= path_async_next;
    end
  end

  // ****************************************************************
  // read mux and interrupt
  // ****************************************************************
  word_t rd_word;
  word_t enable_word;
  word_t flag_word;
  word_t path_word;
  wire   irq_next;

  // unused positions tie to zero
  assign enable_word = {18'h00000, en_evd_reg, 2'h0, en_ovr_reg};
  assign flag_word   = {18'h00000, flag_evd_reg, 2'h0, flag_ovr_reg};
  assign path_word   = {26'h0000000, path_async_reg};
  // unmapped addresses read zero with OKAY
  assign rd_word = (haddr == `ENABLE_SET_OFS)   ? enable_word :
                   (haddr == `ENABLE_CLEAR_OFS) ? enable_word :
                   (haddr == `FLAG_OFS)         ? flag_word   :
                   (haddr == `PATH_ASYNC_OFS)   ? path_word   :
                   32'h00000000;
  // registered so irq comes straight from a flop
  assign irq_next = |((flag_evd_next & en_evd_next) |
                      (flag_ovr_next & en_ovr_next));

  // read data registered for the data phase; zero-wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq       <= 1'b0;
    end else begin
      hrdata    <= rd_now ? rd_word : 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq       <= irq_next;
    end
  end

endmodule : event_channel_irq_logic

// *** tb/event_chan_model.sv ***
`timescale 1ns/1ps
// ****
// event channel side
// ****
module event_chan_model
(
  input  wire logic       hclk,
  input  wire logic [5:0] ev_req,
  input  wire logic [5:0] ov_req,
  output logic      [5:0] channel_event_seen,
  output logic      [5:0] channel_overrun
);
  // strobes last one cycle, as real channels hand them over
  always_ff @(posedge hclk) begin
    channel_event_seen <= ev_req;
    channel_overrun <= ov_req;
  end
endmodule : event_chan_model

// *** tb/event_channel_irq_logic_chk.sv ***
`timescale 1ns/1ps
// ****
// checker
// ****
module event_channel_irq_logic_chk
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [5:0]  channel_event_seen,
  input wire logic [5:0]  channel_overrun,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // accepted transfers and channel activity
  wire wr = hsel && htrans[1] && hwrite;
  wire rd = hsel && htrans[1] && !hwrite;
  wire ev = |{channel_event_seen, channel_overrun};
  rdy_high_a: assert property (hreadyout) else $error("wait state");
  resp_okay_a: assert property (!hresp) else $error("bad response");
  zero_fill_a: assert property ($past(rd) |->
    hrdata[31:14] == 0 && hrdata[7:6] == 0) else $error("unused bits");
  idle_data_a: assert property (!$past(rd) |-> hrdata == 0)
    else $error("stray data");
  irq_rise_a: assert property ($rose(irq) |-> $past(ev) || $past(wr, 2))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr, 2))
    else $error("irq fell without write");
  irq_steady_a: assert property (!$past(ev) && !$past(wr, 2) |-> $stable(irq))
    else $error("irq moved");
  flag_clear_a: assert property ($past(wr && haddr == 12'h018, 2) &&
    $past(hwdata) == 32'h3f3f && !$past(ev) |-> !irq) else $error("clear");
  cover property (irq);
  cover property ($fell(irq));
  cover property (rd && haddr == 12'h018);
endmodule : event_channel_irq_logic_chk
bind event_channel_irq_logic event_channel_irq_logic_chk i_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .channel_event_seen(channel_event_seen),
  .channel_overrun(channel_overrun), .irq(irq));

// *** tb/event_channel_irq_logic_tb_top.sv ***
`timescale 1ns/1ps
// ****
// bench
// ****
module event_channel_irq_logic_tb_top
  import event_irq_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rdy, hresp, irq;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  word_t hwdata = '0, hrdata, d;
  chan_vec_t ev_req = '0, ov_req = '0, evs, ovr;
  int n_errors = 0, n_tests = 0, cyc = 0;
  // 8 ns clock
  always #4 hclk = ~hclk;
  event_chan_model i_src (.hclk(hclk), .ev_req(ev_req), .ov_req(ov_req),
    .channel_event_seen(evs), .channel_overrun(ovr));
  event_channel_irq_logic i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(rdy), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(rdy),
    .hresp(hresp), .channel_event_seen(evs), .channel_overrun(ovr), .irq(irq));
  // hang guard, far above the run length
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  task finish_test;
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task chk(input word_t got, input word_t exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // ready seen at negedge stands until the next rising edge
  task ack;
    do @(negedge hclk); while (rdy !== 1'b1);
  endtask : ack
  task xfer(input logic w, input logic [11:0] a, input word_t v);
    hsel <= 1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= w;
    ack; @(posedge hclk);
    hsel <= 0; htrans <= HTRANS_IDLE; hwdata <= v;
    ack; @(posedge hclk); d = hrdata;
  endtask : xfer
  task rchk(input logic [11:0] a, input word_t e);
    xfer(0, a, 0); chk(d, e);
  endtask : rchk
  task pulse(input chan_vec_t e, input chan_vec_t o);
    ev_req <= e; ov_req <= o; @(posedge hclk);
    ev_req <= 0; ov_req <= 0; repeat (2) @(posedge hclk);
  endtask : pulse
  // register sequences
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    rchk(12'h014, 0);
    rchk(12'h018, 0);
    xfer(1, 12'h014, 32'h2a15);
    xfer(1, 12'h014, 0);
    rchk(12'h014, 32'h2a15);
    rchk(12'h010, 32'h2a15);
    xfer(1, 12'h010, 32'h0a05);
    rchk(12'h014, 32'h2010);
    xfer(1, 12'h014, 32'h3f3f);
    pulse(6'h21, 6'h12);
    chk(word_t'(irq), 1);
    xfer(1, 12'h018, 0);
    rchk(12'h018, 32'h2112);
    xfer(1, 12'h018, 32'h2100);
    rchk(12'h018, 32'h0012);
    xfer(1, 12'h018, 32'h3f3f);
    rchk(12'h018, 0);
    xfer(1, 12'h010, 32'h3f3f);
    pulse(6'h01, 6'h20);
    chk(word_t'(irq), 0);
    rchk(12'h018, 32'h0120);
    xfer(1, 12'h018, 32'h3f3f);
    fork xfer(1, 12'h018, 32'h0100); pulse(6'h01, 0); join
    rchk(12'h018, 32'h0100);
    xfer(1, 12'h018, 32'h3f3f);
    xfer(1, 12'h01c, 32'h3f);
    pulse(6'h3f, 6'h3f);
    rchk(12'h018, 0);
    rchk(12'h040, 0);
    finish_test();
  end
endmodule : event_channel_irq_logic_tb_top
